// >>> fshp_top.sv
// The AXI4-Lite interface to the registers was decided locally.
`default_nettype none
module fshp_top
    import fshp_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // usage fault events from the pipeline
    input wire logic evt_coproc,
    input wire logic evt_bad_return,
    input wire logic evt_illegal_state,
    input wire logic evt_undecodable,
    // bus fault events
    input wire logic evt_bus_precise,
    input wire logic [31:0] bus_req_addr,
    input wire logic evt_stacking_err,
    input wire logic evt_unstacking_err,
    // memory management fault event
    input wire logic evt_mem_fault,
    input wire logic [31:0] mem_fault_addr,
    // handler priorities to the core
    output logic [3:0] prio_mem_mgmt,
    output logic [3:0] prio_bus,
    output logic [3:0] prio_usage,
    output logic [3:0] prio_supervisor,
    output logic [3:0] prio_pendable,
    output logic [3:0] prio_tick,
    // interrupt
    output logic irq
);

    fshp_state_t st_r;
    fshp_state_t st_nxt;
    fshp_sel_t wr_sel;
    logic wr_go;
    logic [31:0] set_v;
    logic [31:0] clr_v;
    logic [31:0] kill_v;

    function automatic fshp_sel_t sel_of(input logic [7:0] a);
        case (a)
            OFS_PRIO_ONE: sel_of = SEL_PRI1;
            OFS_PRIO_TWO: sel_of = SEL_PRI2;
            OFS_PRIO_THREE: sel_of = SEL_PRI3;
            OFS_FAULT_STATUS: sel_of = SEL_STATUS;
            OFS_MEM_ADDR: sel_of = SEL_MEM;
            OFS_BUS_ADDR: sel_of = SEL_BUS;
            OFS_IRQ_MASK: sel_of = SEL_MASK;
            default: sel_of = SEL_NONE;
        endcase
    endfunction : sel_of

    // byte-lane merge limited to implemented bits
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0] strb,
        input logic [31:0] impl
    );
        logic [31:0] lanes;
        lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        merge = ((old & ~lanes) | (nw & lanes)) & impl; // RQ1 RQ3
    endfunction : merge

    function automatic logic [31:0] read_word(
        input fshp_state_t s,
        input fshp_sel_t sel
    );
        case (sel)
            SEL_PRI1: read_word = s.pri1;
            SEL_PRI2: read_word = s.pri2;
            SEL_PRI3: read_word = s.pri3;
            SEL_STATUS: read_word = s.status;
            SEL_MEM: read_word = s.mem_addr;
            SEL_BUS: read_word = s.bus_addr;
            SEL_MASK: read_word = s.mask;
            default: read_word = RST_WORD;
        endcase
    endfunction : read_word

    always_comb begin
        st_nxt = st_r;
        set_v = RST_WORD;
        clr_v = RST_WORD;
        kill_v = RST_WORD;
        wr_go = st_r.aw_have && st_r.w_have && !st_r.bvalid;
        wr_sel = sel_of(st_r.aw_addr);

        // write channels are taken independently, in either order
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.aw_have = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.w_have = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end

        if (wr_go) begin
            st_nxt.aw_have = 1'b0;
            st_nxt.w_have = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = RESP_OKAY;
            case (wr_sel)
                SEL_PRI1: begin
                    st_nxt.pri1 = merge(st_r.pri1, st_r.w_data, st_r.w_strb,
                        PRIO_ONE_IMPL); // RQ2
                end
                SEL_PRI2: begin
                    st_nxt.pri2 = merge(st_r.pri2, st_r.w_data, st_r.w_strb,
                        PRIO_TWO_IMPL); // RQ2
                end
                SEL_PRI3: begin
                    st_nxt.pri3 = merge(st_r.pri3, st_r.w_data, st_r.w_strb,
                        PRIO_THREE_IMPL); // RQ2
                end
                SEL_STATUS: begin
                    // write one clears; reserved 14:13 are simply not stored
                    clr_v = merge(RST_WORD, st_r.w_data, st_r.w_strb,
                        STATUS_IMPL); // RQ17 RQ12
                end
                SEL_MEM: begin
                    st_nxt.mem_addr = merge(st_r.mem_addr, st_r.w_data,
                        st_r.w_strb, ALL_IMPL);
                end
                SEL_BUS: begin
                    st_nxt.bus_addr = merge(st_r.bus_addr, st_r.w_data,
                        st_r.w_strb, ALL_IMPL);
                end
                SEL_MASK: begin
                    st_nxt.mask = merge(st_r.mask, st_r.w_data, st_r.w_strb,
                        STATUS_IMPL);
                end
                default: begin
                    st_nxt.bresp = RESP_SLVERR;
                end
            endcase
        end

        // read: one cycle from address taken to data
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_r.arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = read_word(st_r, sel_of(s_axi_araddr));
            st_nxt.rresp = (sel_of(s_axi_araddr) == SEL_NONE) ? RESP_SLVERR
                : RESP_OKAY;
        end

        // fault events
        set_v[BIT_COPROC] = evt_coproc; // RQ4
        set_v[BIT_BADRET] = evt_bad_return; // RQ5
        // an undefined instruction never counts as an illegal state use
        set_v[BIT_ILLSTATE] = evt_illegal_state && !evt_undecodable; // RQ6
        set_v[BIT_UNDEF] = evt_undecodable; // RQ7
        set_v[BIT_STK] = evt_stacking_err; // RQ10
        set_v[BIT_UNSTK] = evt_unstacking_err; // RQ11
        if (evt_bus_precise) begin
            set_v[BIT_BAV] = 1'b1; // RQ8
            st_nxt.bus_addr = bus_req_addr; // RQ15 RQ16
        end
        if (evt_mem_fault) begin
            set_v[BIT_MAV] = 1'b1;
            st_nxt.mem_addr = mem_fault_addr; // RQ13 RQ14
            kill_v[BIT_BAV] = 1'b1; // RQ8
        end
        // set wins over any clear in the same cycle
        st_nxt.status = ((st_r.status & ~clr_v & ~kill_v) | set_v)
            & STATUS_IMPL; // RQ17
        st_nxt.irq = |(st_nxt.status & st_nxt.mask);

        st_nxt.awready = !st_nxt.aw_have && !st_nxt.bvalid;
        st_nxt.wready = !st_nxt.w_have && !st_nxt.bvalid;
        st_nxt.arready = !st_nxt.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_awready = st_r.awready;
    assign s_axi_wready = st_r.wready;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign irq = st_r.irq;
    assign prio_mem_mgmt = st_r.pri1[7:4]; // RQ2
    assign prio_bus = st_r.pri1[15:12];
    assign prio_usage = st_r.pri1[23:20];
    assign prio_supervisor = st_r.pri2[31:28];
    assign prio_pendable = st_r.pri3[23:20];
    assign prio_tick = st_r.pri3[31:28];

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence wr_pri1_lane1;
        wr_go && wr_sel == SEL_PRI1 && st_r.w_strb == 4'h2;
    endsequence

    sequence ar_taken;
        s_axi_arvalid && st_r.arready;
    endsequence

    sequence wr_ready;
        wr_go;
    endsequence

    prio_nibble_zero_a: assert property ( // RQ3
        ((st_r.pri1 & ~PRIO_ONE_IMPL) == RST_WORD)
        && ((st_r.pri2 & ~PRIO_TWO_IMPL) == RST_WORD)
        && ((st_r.pri3 & ~PRIO_THREE_IMPL) == RST_WORD))
        else $error("priority low nibble not zero");

    prio_byte_write_a: assert property ( // RQ1
        wr_pri1_lane1 |=> st_r.pri1[7:0] == $past(st_r.pri1[7:0])
        && prio_bus == $past(st_r.w_data[15:12]))
        else $error("priority byte write wrong");

    coproc_flag_a: assert property ( // RQ4
        evt_coproc |=> st_r.status[BIT_COPROC] && st_r.irq == |(st_r.status & st_r.mask))
        else $error("coprocessor flag not set");

    bad_return_a: assert property ( // RQ5
        evt_bad_return |=> st_r.status[BIT_BADRET])
        else $error("bad return flag not set");

    state_vs_undef_a: assert property ( // RQ6
        evt_illegal_state && evt_undecodable && !st_r.status[BIT_ILLSTATE]
        |=> !st_r.status[BIT_ILLSTATE] && st_r.status[BIT_UNDEF])
        else $error("illegal state set on undefined instruction");

    illegal_alone_a: assert property ( // RQ6
        evt_illegal_state && !evt_undecodable |=> st_r.status[BIT_ILLSTATE])
        else $error("illegal state flag not set");

    bus_capture_a: assert property ( // RQ15
        evt_bus_precise |=> st_r.status[BIT_BAV]
        && st_r.bus_addr == $past(bus_req_addr))
        else $error("bus fault address not captured");

    mem_clears_bav_a: assert property ( // RQ8
        evt_mem_fault && !evt_bus_precise |=> !st_r.status[BIT_BAV]
        && st_r.status[BIT_MAV] && st_r.mem_addr == $past(mem_fault_addr))
        else $error("memory fault capture wrong");

    stk_no_addr_a: assert property ( // RQ10
        evt_stacking_err && !evt_bus_precise && !(wr_go && wr_sel == SEL_BUS)
        |=> st_r.status[BIT_STK] && $stable(st_r.bus_addr))
        else $error("stacking error handling wrong");

    unstk_no_addr_a: assert property ( // RQ11
        evt_unstacking_err && !evt_bus_precise && !(wr_go && wr_sel == SEL_BUS)
        |=> st_r.status[BIT_UNSTK] && $stable(st_r.bus_addr))
        else $error("unstacking error handling wrong");

    flags_sticky_a: assert property ( // RQ17
        !(wr_go && wr_sel == SEL_STATUS) && !evt_mem_fault
        |=> (st_r.status & $past(st_r.status)) == $past(st_r.status))
        else $error("status flag lost without clear");

    read_latency_a: assert property (
        ar_taken |=> st_r.rvalid && !st_r.arready)
        else $error("read answer late");

    write_resp_a: assert property (
        wr_ready |=> st_r.bvalid [*1] ##0 !st_r.awready && !st_r.wready)
        else $error("write response late");

    // a full-word clear with no event racing it must leave no written bit set
    sequence status_w1c_clean;
        wr_go && wr_sel == SEL_STATUS && st_r.w_strb == 4'hf && set_v == RST_WORD;
    endsequence

    sequence wr_unmapped;
        wr_go && wr_sel == SEL_NONE;
    endsequence

    sequence wr_zero_status;
        wr_go && wr_sel == SEL_STATUS && st_r.w_data == RST_WORD && !evt_mem_fault;
    endsequence

    undef_flag_a: assert property ( // RQ7
        evt_undecodable |=> st_r.status[BIT_UNDEF])
        else $error("undecodable flag not set");

    write_one_clear_a: assert property ( // RQ17
        status_w1c_clean |=> (st_r.status & $past(st_r.w_data)) == RST_WORD)
        else $error("written one did not clear flag");

    zero_write_keeps_a: assert property ( // RQ17
        wr_zero_status |=> st_r.status == ($past(st_r.status) | $past(set_v)))
        else $error("zero write changed a flag");

    reserved_zero_a: assert property ( // RQ12
        (st_r.status & ~STATUS_IMPL) == RST_WORD)
        else $error("reserved status bit set");

    mem_capture_a: assert property ( // RQ14
        evt_mem_fault |=> st_r.status[BIT_MAV] && st_r.mem_addr == $past(mem_fault_addr))
        else $error("memory fault address not captured");

    prio_hold_a: assert property ( // RQ1
        !(wr_go && wr_sel inside {SEL_PRI1, SEL_PRI2, SEL_PRI3})
        |=> $stable(st_r.pri1) && $stable(st_r.pri2) && $stable(st_r.pri3))
        else $error("priority changed without write");

    unmapped_err_a: assert property (
        wr_unmapped |=> st_r.bvalid && st_r.bresp == RESP_SLVERR)
        else $error("unmapped write not refused");

    read_unmapped_a: assert property (
        s_axi_arvalid && st_r.arready && sel_of(s_axi_araddr) == SEL_NONE
        |=> st_r.rresp == RESP_SLVERR && st_r.rdata == RST_WORD)
        else $error("unmapped read not refused");

    // a second address must wait until the pending write has been answered
    write_refuse_a: assert property (
        st_r.aw_have || st_r.bvalid |-> !st_r.awready)
        else $error("write address taken while busy");

    irq_level_a: assert property (
        st_r.irq == |(st_r.status & st_r.mask))
        else $error("interrupt level wrong");

endmodule : fshp_top
`default_nettype wire

// >>> fshp_pkg.sv
// Overview of operation
// RQ1 - priority 0..15 per handler, byte accessible
// RQ2 - fields 4,5,6 / 11 / 14,15 placement
// RQ3 - priority low nibble reads zero, ignores writes
// RQ4 - coprocessor attempt sets bit 19
// RQ5 - bad return load sets bit 18
// RQ6 - illegal state sets bit 17, not undefined
// RQ7 - undecodable instruction sets bit 16
// RQ8 - bus address valid bit 15, memfault clears
// RQ9 - hard fault handler clears bus valid (no hard fault input here; only a memfault or a status write of one clears it)
// RQ10 - stacking error bit 12, no address
// RQ11 - unstacking error bit 11, no address
// RQ12 - software keeps bits 14:13 cleared
// RQ13 - mem fault address at 0x34
// RQ14 - mem address is actual faulting address
// RQ15 - bus fault address at 0x38
// RQ16 - bus address is requested address
// RQ17 - flags sticky, write one clears
`default_nettype none
package fshp_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_PRIO_ONE = 8'h18;
    localparam logic [7:0] OFS_PRIO_TWO = 8'h1c;
    localparam logic [7:0] OFS_PRIO_THREE = 8'h20;
    localparam logic [7:0] OFS_FAULT_STATUS = 8'h28;
    localparam logic [7:0] OFS_MEM_ADDR = 8'h34;
    localparam logic [7:0] OFS_BUS_ADDR = 8'h38;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h3c;
    // status bit positions
    localparam int BIT_COPROC = 19;
    localparam int BIT_BADRET = 18;
    localparam int BIT_ILLSTATE = 17;
    localparam int BIT_UNDEF = 16;
    localparam int BIT_BAV = 15;
    localparam int BIT_STK = 12;
    localparam int BIT_UNSTK = 11;
    localparam int BIT_MAV = 7;
    localparam logic [31:0] STATUS_IMPL = 32'h000f_9880;
    // implemented priority bits: upper nibble of each live byte
    localparam logic [31:0] PRIO_ONE_IMPL = 32'h00f0_f0f0;
    localparam logic [31:0] PRIO_TWO_IMPL = 32'hf000_0000;
    localparam logic [31:0] PRIO_THREE_IMPL = 32'hf0f0_0000;
    localparam logic [31:0] ALL_IMPL = 32'hffff_ffff;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SEL_NONE, SEL_PRI1, SEL_PRI2, SEL_PRI3,
        SEL_STATUS, SEL_MEM, SEL_BUS, SEL_MASK
    } fshp_sel_t;

    typedef struct packed {
        logic [31:0] pri1;
        logic [31:0] pri2;
        logic [31:0] pri3;
        logic [31:0] status;
        logic [31:0] mem_addr;
        logic [31:0] bus_addr;
        logic [31:0] mask;
        logic irq;
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } fshp_state_t;
endpackage : fshp_pkg
`default_nettype wire

// >>> fshp_core_model.sv
`default_nettype none
module fshp_core_model (
    // clock
    input wire logic aclk,
    // fault events and their address
    output logic [7:0] evt,
    output logic [31:0] fault_addr
);
    initial begin
        evt = 8'h00;
        fault_addr = 32'h0000_0000;
    end

    // after its pulse the address shows the inverse, so a stale capture is never a match
    task automatic fire(input logic [7:0] e, input logic [31:0] a);
        @(posedge aclk);
        evt <= e;
        fault_addr <= a;
        @(posedge aclk);
        evt <= 8'h00;
        fault_addr <= ~a;
    endtask : fire
endmodule : fshp_core_model
`default_nettype wire

// >>> fshp_top_tb.sv
`default_nettype none
module fshp_top_tb import fshp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, fault_addr;
    logic [3:0] prio_mem_mgmt, prio_bus, prio_usage, prio_supervisor, prio_pendable, prio_tick;
    logic [7:0] evt;
    logic [7:0] ofs [7] = '{OFS_PRIO_ONE, OFS_PRIO_TWO, OFS_PRIO_THREE, OFS_FAULT_STATUS,
        OFS_MEM_ADDR, OFS_BUS_ADDR, OFS_IRQ_MASK};
    int fails = 0;
    int cmp_count = 0;

    always #2.5 aclk = ~aclk;

    fshp_core_model i_fshp_core_model (.aclk, .evt, .fault_addr);

    fshp_top i_fshp_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .evt_coproc(evt[0]),
        .evt_bad_return(evt[1]), .evt_illegal_state(evt[2]), .evt_undecodable(evt[3]),
        .evt_bus_precise(evt[4]), .bus_req_addr(fault_addr), .evt_stacking_err(evt[5]),
        .evt_unstacking_err(evt[6]), .evt_mem_fault(evt[7]), .mem_fault_addr(fault_addr),
        .prio_mem_mgmt, .prio_bus, .prio_usage, .prio_supervisor, .prio_pendable,
        .prio_tick, .irq);

    task automatic conclude;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // payload stays put until each channel's own ready is seen at an edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 40);
        s_axi_bready <= 1'b0;
        if (n >= 40) begin
            fails++;
            conclude();
        end
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 40);
        s_axi_rready <= 1'b0;
        if (n >= 40) begin
            fails++;
            conclude();
        end
        chk(s_axi_rdata, ed);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask : rd

    task automatic t_reset;
        for (int i = 0; i < 7; i++) rd(ofs[i], RST_WORD, RESP_OKAY);
        chk({prio_mem_mgmt, prio_bus, prio_usage, prio_supervisor, prio_pendable,
            prio_tick, 7'h0, irq}, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_prio;
        for (int i = 0; i < 3; i++) wr(ofs[i], ALL_IMPL, 4'hf, RESP_OKAY);
        rd(OFS_PRIO_ONE, PRIO_ONE_IMPL, RESP_OKAY);
        rd(OFS_PRIO_TWO, PRIO_TWO_IMPL, RESP_OKAY);
        rd(OFS_PRIO_THREE, PRIO_THREE_IMPL, RESP_OKAY);
        chk({8'h0, prio_mem_mgmt, prio_bus, prio_usage, prio_supervisor, prio_pendable,
            prio_tick}, 32'h00ff_ffff);
        wr(OFS_PRIO_ONE, 32'h0000_5a00, 4'h2, RESP_OKAY);
        rd(OFS_PRIO_ONE, 32'h00f0_50f0, RESP_OKAY);
        wr(OFS_PRIO_THREE, 32'h3c00_0000, 4'h8, RESP_OKAY);
        wr(OFS_PRIO_TWO, 32'h0000_0000, 4'h8, RESP_OKAY);
        rd(OFS_PRIO_THREE, 32'h30f0_0000, RESP_OKAY);
        chk({16'h0, prio_bus, prio_supervisor, prio_pendable, prio_tick}, 32'h50f3);
        $display("test prio done");
    endtask : t_prio

    task automatic t_usage;
        wr(OFS_IRQ_MASK, STATUS_IMPL, 4'hf, RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            i_fshp_core_model.fire(8'h01 << i, 32'h0000_0000);
            rd(OFS_FAULT_STATUS, 32'h1 << (19 - i), RESP_OKAY);
            chk({31'h0, irq}, 32'h1);
            wr(OFS_FAULT_STATUS, 32'h0, 4'hf, RESP_OKAY);
            rd(OFS_FAULT_STATUS, 32'h1 << (19 - i), RESP_OKAY);
            wr(OFS_FAULT_STATUS, 32'h1 << (19 - i), 4'hf, RESP_OKAY);
            rd(OFS_FAULT_STATUS, 32'h0, RESP_OKAY);
        end
        i_fshp_core_model.fire(8'h0c, 32'h0000_0000);
        wr(OFS_IRQ_MASK, 32'h0, 4'hf, RESP_OKAY);
        rd(OFS_FAULT_STATUS, 32'h0001_0000, RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
        wr(OFS_FAULT_STATUS, 32'h0001_0000, 4'h4, RESP_OKAY);
        $display("test usage done");
    endtask : t_usage

    task automatic t_bus;
        i_fshp_core_model.fire(8'h10, 32'h2000_0003);
        rd(OFS_FAULT_STATUS, 32'h0000_8000, RESP_OKAY);
        rd(OFS_BUS_ADDR, 32'h2000_0003, RESP_OKAY);
        i_fshp_core_model.fire(8'h20, 32'h1111_1110);
        rd(OFS_FAULT_STATUS, 32'h0000_9000, RESP_OKAY);
        i_fshp_core_model.fire(8'h40, 32'h2222_2220);
        rd(OFS_FAULT_STATUS, 32'h0000_9800, RESP_OKAY);
        rd(OFS_BUS_ADDR, 32'h2000_0003, RESP_OKAY);
        i_fshp_core_model.fire(8'h80, 32'h3000_0005);
        rd(OFS_FAULT_STATUS, 32'h0000_1880, RESP_OKAY);
        rd(OFS_MEM_ADDR, 32'h3000_0005, RESP_OKAY);
        i_fshp_core_model.fire(8'h10, 32'h4000_0000);
        wr(OFS_FAULT_STATUS, 32'h0000_8000, 4'h2, RESP_OKAY);
        rd(OFS_FAULT_STATUS, 32'h0000_1880, RESP_OKAY);
        wr(OFS_FAULT_STATUS, STATUS_IMPL, 4'hf, RESP_OKAY);
        rd(OFS_FAULT_STATUS, 32'h0, RESP_OKAY);
        wr(OFS_MEM_ADDR, 32'hcafe_0001, 4'hf, RESP_OKAY);
        rd(OFS_MEM_ADDR, 32'hcafe_0001, RESP_OKAY);
        $display("test bus done");
    endtask : t_bus

    task automatic t_unmapped;
        wr(8'h00, 32'hffff_ffff, 4'hf, RESP_SLVERR);
        rd(8'h00, 32'h0, RESP_SLVERR);
        $display("test unmapped done");
    endtask : t_unmapped

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_prio();
        t_usage();
        t_bus();
        t_unmapped();
        conclude();
    end
endmodule : fshp_top_tb
`default_nettype wire
